/* lcdce_consts.vh */
// constants for the display command executor
// Overview of operation
// - upper nibble 1100 is mode-set; bit 3 enables the display, 0 blanks it.
// - mode-set bit 2 picks half or third bias; low two bits pick drive mode.
// - bit 7 clear loads seven-bit data pointer; host keeps it within 0 to 59.
// - upper five bits 11100 select a device subaddress from low three bits.
// - bank-select bit 1 routes arriving display data to lower or upper RAM bank.
// - bank-select bit 0 picks which RAM bank feeds dispBankBits; dispData always carries the whole RAM nibble.
// - bank-select is ignored in three and four backplane drive modes.
// - upper five bits 11110 set blink mode bit 2 and blink rate field.
// - three and four backplane modes use normal blinking only.
// - decoded commands update status registers which jointly steer the display.
// - display bytes are stored in the order set by drive mode and input bank.
// - control byte bit 7 is continuation flag, bit 6 selects command or data.
// - each stored display byte advances data pointer; wrapping past 59 advances subaddress counter.
// - only a matching subaddress acknowledges and stores display bytes.
`ifndef LCDCE_CONSTS_VH
`define LCDCE_CONSTS_VH
`define LCDCE_MODE_STATIC 2'h1
`define LCDCE_MODE_MUX2 2'h2
`define LCDCE_MODE_MUX3 2'h3
`define LCDCE_MODE_MUX4 2'h0
`define LCDCE_PTR_MAX 7'h3B
`define LCDCE_RAM_DEPTH 60
`define LCDCE_CONT_BIT 7
`define LCDCE_SEL_BIT 6
`define LCDCE_OP_NONE 3'h0
`define LCDCE_OP_MODE 3'h1
`define LCDCE_OP_PTR 3'h2
`define LCDCE_OP_DEV 3'h3
`define LCDCE_OP_BANK 3'h4
`define LCDCE_OP_BLINK 3'h5
`define LCDCE_RST_MODE 2'h0
`endif

/* lcdce_decode.v */
// opcode classifier for command bytes
`timescale 1ns/1ps
`include "lcdce_consts.vh"
module lcdce_decode (
    input wire [7:0] cmdByte,
    output reg [2:0] opKind
);
    // ==========================================
    // opcode match
    always @* begin
        if (cmdByte[7] == 1'b0)
            opKind = `LCDCE_OP_PTR;
        else if (cmdByte[7:4] == 4'hC)
            opKind = `LCDCE_OP_MODE;
        else if (cmdByte[7:3] == 5'h1C)
            opKind = `LCDCE_OP_DEV;
        else if (cmdByte[7:2] == 6'h3E)
            opKind = `LCDCE_OP_BANK;
        else if (cmdByte[7:3] == 5'h1E)
            opKind = `LCDCE_OP_BLINK;
        else
            opKind = `LCDCE_OP_NONE;
    end
endmodule

/* lcdce_ram.v */
// 60 x 4 display ram with nibble write mask
`timescale 1ns/1ps
`include "lcdce_consts.vh"
module lcdce_ram (
    input wire core_clk,
    input wire wrEn,
    input wire [5:0] wrAddr,
    input wire [3:0] wrData,
    input wire [3:0] wrMask,
    input wire [5:0] rdAddr,
    output reg [3:0] rdData
);
    reg [3:0] mem [0:`LCDCE_RAM_DEPTH-1];
    // ==========================================
    // masked write, registered read
    always @(posedge core_clk) begin
        if (wrEn && wrAddr < `LCDCE_RAM_DEPTH)
            mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
        rdData <= (rdAddr < `LCDCE_RAM_DEPTH) ? mem[rdAddr] : 4'h0;
    end
endmodule

/* lcdce_executor.v */
// command interpreter and display data store
`timescale 1ns/1ps
`include "lcdce_consts.vh"
module lcdce_executor (
    input wire core_clk,
    input wire srst,
    input wire byteValid,
    input wire [7:0] byteData,
    input wire frameStart,
    input wire [2:0] hwSubaddr,
    input wire [5:0] dispRdAddr,
    output reg byteAck,
    output reg displayEnable,
    output reg halfBias,
    output reg [1:0] driveMode,
    output reg [2:0] subaddr,
    output reg [6:0] dataPtr,
    output reg inputBank,
    output reg outputBank,
    output reg blinkAlternate,
    output reg [1:0] blinkRate,
    output reg [3:0] dispData,
    output reg [1:0] dispBankBits
);
    localparam ST_CTRL = 2'h0;
    localparam ST_CMD = 2'h1;
    localparam ST_DATA = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;
    reg lastCtrl;
    wire [2:0] opKind;
    wire [3:0] ramRd;
    reg ramWr;
    reg [3:0] wrData;
    reg [3:0] wrMask;
    reg [2:0] ptrStep;

    // ==========================================
    // mode predicate
    function isMultiBank;
        input [1:0] mode;
        begin
            isMultiBank = (mode == `LCDCE_MODE_MUX3) || (mode == `LCDCE_MODE_MUX4);
        end
    endfunction

    lcdce_decode uDecode (
        .cmdByte(byteData),
        .opKind(opKind)
    );

    lcdce_ram uRam (
        .core_clk(core_clk),
        .wrEn(ramWr),
        .wrAddr(dataPtr[5:0]),
        .wrData(wrData),
        .wrMask(wrMask),
        .rdAddr(dispRdAddr),
        .rdData(ramRd)
    );

    // ==========================================
    // byte framing
    always @* begin
        next_state = state;
        if (frameStart)
            next_state = ST_CTRL;
        else if (byteValid) begin
            case (state)
                ST_CTRL: begin
                    if (byteData[`LCDCE_SEL_BIT])
                        next_state = ST_DATA;
                    else
                        next_state = ST_CMD;
                end
                ST_CMD: next_state = lastCtrl ? ST_CMD : ST_CTRL;
                ST_DATA: next_state = ST_DATA;
                default: next_state = ST_CTRL;
            endcase
        end
    end

    // ==========================================
    // display byte storage order
    always @* begin
        ramWr = 1'b0;
        wrData = 4'h0;
        wrMask = 4'h0;
        ptrStep = 3'h0;
        if (byteValid && !frameStart && state == ST_DATA && subaddr == hwSubaddr) begin
            ramWr = 1'b1;
            case (driveMode)
                `LCDCE_MODE_STATIC: begin
                    ptrStep = 3'h1;
                    wrMask = inputBank ? 4'h4 : 4'h1;
                    wrData = {1'b0, byteData[7], 1'b0, byteData[7]};
                end
                `LCDCE_MODE_MUX2: begin
                    ptrStep = 3'h1;
                    wrMask = inputBank ? 4'hC : 4'h3;
                    wrData = {byteData[7:6], byteData[7:6]};
                end
                `LCDCE_MODE_MUX3: begin
                    ptrStep = 3'h1;
                    wrMask = 4'h7;
                    wrData = {1'b0, byteData[7:5]};
                end
                default: begin
                    ptrStep = 3'h1;
                    wrMask = 4'hF;
                    wrData = byteData[7:4];
                end
            endcase
        end
    end

    // ==========================================
    // status registers
    always @(posedge core_clk) begin
        if (srst) begin
            state <= ST_CTRL;
            lastCtrl <= 1'b0;
            byteAck <= 1'b0;
            displayEnable <= 1'b0;
            halfBias <= 1'b0;
            driveMode <= `LCDCE_RST_MODE;
            subaddr <= 3'h0;
            dataPtr <= 7'h00;
            inputBank <= 1'b0;
            outputBank <= 1'b0;
            blinkAlternate <= 1'b0;
            blinkRate <= 2'h0;
            dispData <= 4'h0;
            dispBankBits <= 2'h0;
        end else begin
            state <= next_state;
            byteAck <= 1'b0;
            if (byteValid && !frameStart) begin
                byteAck <= (state != ST_DATA) || (subaddr == hwSubaddr);
                if (state == ST_CTRL)
                    lastCtrl <= ~byteData[`LCDCE_CONT_BIT];
            end
            if (byteValid && !frameStart && state == ST_CMD) begin
                case (opKind)
                    `LCDCE_OP_MODE: begin
                        displayEnable <= byteData[3];
                        halfBias <= byteData[2];
                        driveMode <= byteData[1:0];
                        if (isMultiBank(byteData[1:0]))
                            blinkAlternate <= 1'b0;
                    end
                    `LCDCE_OP_PTR: dataPtr <= byteData[6:0];
                    `LCDCE_OP_DEV: subaddr <= byteData[2:0];
                    `LCDCE_OP_BANK: begin
                        if (!isMultiBank(driveMode)) begin
                            inputBank <= byteData[1];
                            outputBank <= byteData[0];
                        end
                    end
                    `LCDCE_OP_BLINK: begin
                        blinkRate <= byteData[1:0];
                        blinkAlternate <= byteData[2] & ~isMultiBank(driveMode);
                    end
                    default: ;
                endcase
            end
            if (ramWr) begin
                if (dataPtr >= `LCDCE_PTR_MAX) begin
                    dataPtr <= 7'h00;
                    subaddr <= subaddr + 3'h1;
                end else
                    dataPtr <= dataPtr + {4'h0, ptrStep};
            end
            // output bank selects nibble half in static and duplex modes
            dispData <= ramRd;
            if (isMultiBank(driveMode))
                dispBankBits <= ramRd[1:0];
            else
                dispBankBits <= outputBank ? ramRd[3:2] : ramRd[1:0];
        end
    end
endmodule

/* lcdce_monitor.sv */
// checker for the command executor ports
`timescale 1ns/1ps
module lcdce_monitor (
    input wire core_clk,
    input wire srst,
    input wire byteValid,
    input wire [7:0] byteData,
    input wire frameStart,
    input wire [2:0] hwSubaddr,
    input wire byteAck,
    input wire displayEnable,
    input wire halfBias,
    input wire [1:0] driveMode,
    input wire [2:0] subaddr,
    input wire [6:0] dataPtr,
    input wire inputBank,
    input wire outputBank,
    input wire blinkAlternate,
    input wire [1:0] blinkRate
);
    // frame position: control, one command, commands, data
    reg [1:0] st;
    wire tk = byteValid && !frameStart;
    wire cmd = tk && (st == 2'h1 || st == 2'h2);
    wire dat = tk && st == 2'h3;
    wire bank = cmd && byteData[7:2] == 6'h3E;
    wire [11:0] sts = {displayEnable, halfBias, driveMode, subaddr, inputBank, outputBank,
        blinkAlternate, blinkRate};
    always @(posedge core_clk)
        if (srst || frameStart) st <= 2'h0;
        else if (tk && st == 2'h0) st <= byteData[6] ? 2'h3 : {!byteData[7], byteData[7]};
        else if (tk && st == 2'h1) st <= 2'h0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence sStore;
        ##1 (byteAck && dataPtr == ($past(dataPtr) == 7'h3B ? 7'h00 : $past(dataPtr) + 7'h01));
    endsequence
    a_mode_set: assert property (cmd && byteData[7:4] == 4'hC
        |=> {displayEnable, halfBias, driveMode} == $past(byteData[3:0])) else $error("mode");
    a_ptr_load: assert property (cmd && !byteData[7]
        |=> dataPtr == $past(byteData[6:0])) else $error("pointer");
    a_dev_sel: assert property (cmd && byteData[7:3] == 5'h1C
        |=> subaddr == $past(byteData[2:0])) else $error("subaddress");
    a_bank_take: assert property (bank && (driveMode[1] ^ driveMode[0])
        |=> {inputBank, outputBank} == $past(byteData[1:0])) else $error("bank");
    a_bank_ignore: assert property (bank && (driveMode[1] ~^ driveMode[0])
        |=> $stable({inputBank, outputBank})) else $error("bank ignored");
    a_blink_rate: assert property (cmd && byteData[7:3] == 5'h1E
        |=> blinkRate == $past(byteData[1:0])) else $error("blink");
    a_blink_normal: assert property ((driveMode[1] ~^ driveMode[0])
        |-> !blinkAlternate) else $error("alternate");
    a_data_store: assert property (dat && subaddr == hwSubaddr |-> sStore)
        else $error("store");
    a_data_silent: assert property (dat && subaddr != hwSubaddr
        |=> !byteAck && $stable(dataPtr)) else $error("silent");
    a_unknown_cmd: assert property (cmd && byteData[7:4] == 4'hD
        |=> $stable(sts)) else $error("unknown");
endmodule
bind lcdce_executor lcdce_monitor mon (
    .core_clk(core_clk),
    .srst(srst),
    .byteValid(byteValid),
    .byteData(byteData),
    .frameStart(frameStart),
    .hwSubaddr(hwSubaddr),
    .byteAck(byteAck),
    .displayEnable(displayEnable),
    .halfBias(halfBias),
    .driveMode(driveMode),
    .subaddr(subaddr),
    .dataPtr(dataPtr),
    .inputBank(inputBank),
    .outputBank(outputBank),
    .blinkAlternate(blinkAlternate),
    .blinkRate(blinkRate)
);

/* lcdce_master.sv */
// serial master model delivering framed bytes
`timescale 1ns/1ps
module lcdce_master (
    input wire core_clk,
    output reg frameStart,
    output reg byteValid,
    output reg [7:0] byteData
);
    initial begin
        frameStart = 1'h0;
        byteValid = 1'h0;
        byteData = 8'h00;
    end
    task start;
        @(posedge core_clk) frameStart <= 1'h1;
        @(posedge core_clk) frameStart <= 1'h0;
    endtask
    // released data shows the inverse of the last byte
    task send(input [7:0] b);
        @(posedge core_clk);
        byteValid <= 1'h1;
        byteData <= b;
        @(posedge core_clk);
        byteValid <= 1'h0;
        byteData <= ~b;
    endtask
endmodule

/* lcdce_tb.sv */
// self-checking bench for the command executor
`timescale 1ns/1ps
module tb;
    reg core_clk = 1'h0;
    reg srst = 1'h1;
    reg [2:0] hwSubaddr = 3'h2;
    reg [5:0] dispRdAddr = 6'h3B;
    wire frameStart, byteValid, byteAck, displayEnable, halfBias, inputBank, outputBank;
    wire blinkAlternate;
    wire [1:0] driveMode, blinkRate, dispBankBits;
    wire [2:0] subaddr;
    wire [6:0] dataPtr;
    wire [7:0] byteData;
    wire [3:0] dispData;
    wire [11:0] sts = {displayEnable, halfBias, driveMode, subaddr, inputBank, outputBank,
        blinkAlternate, blinkRate};
    integer fail_count = 0;
    integer n_compared = 0;
    always #2 core_clk = ~core_clk;
    lcdce_master m (.core_clk(core_clk), .frameStart(frameStart), .byteValid(byteValid),
        .byteData(byteData));
    lcdce_executor dut (.core_clk(core_clk), .srst(srst), .byteValid(byteValid),
        .byteData(byteData), .frameStart(frameStart), .hwSubaddr(hwSubaddr),
        .dispRdAddr(dispRdAddr), .byteAck(byteAck), .displayEnable(displayEnable),
        .halfBias(halfBias), .driveMode(driveMode), .subaddr(subaddr), .dataPtr(dataPtr),
        .inputBank(inputBank), .outputBank(outputBank), .blinkAlternate(blinkAlternate),
        .blinkRate(blinkRate), .dispData(dispData), .dispBankBits(dispBankBits));
    task conclude;
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input [11:0] got, input [11:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cmd(input [7:0] b, input [11:0] exp);
        m.send(b);
        #1 chk(sts, exp);
    endtask
    // point the display read port and let the two read stages settle
    task look(input [5:0] a);
        @(posedge core_clk) dispRdAddr <= a;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        fail_count = fail_count + 1;
        conclude;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'h0;
        #1 chk({5'h00, dataPtr}, 12'h000);
        chk(sts, 12'h000);
        m.start;
        m.send(8'h00);
        cmd(8'hCD, 12'hD00);
        cmd(8'hFB, 12'hD18);
        cmd(8'hF6, 12'hD1E);
        cmd(8'hE2, 12'hD5E);
        cmd(8'hD5, 12'hD5E);
        cmd(8'h3A, 12'hD5E);
        chk({5'h00, dataPtr}, 12'h03A);
        cmd(8'hC3, 12'h35A);
        cmd(8'hF8, 12'h35A);
        m.start;
        m.send(8'h80);
        cmd(8'hCA, 12'hA5A);
        m.send(8'h80);
        cmd(8'hFA, 12'hA52);
        m.send(8'h80);
        cmd(8'h3B, 12'hA52);
        m.send(8'h40);
        m.send(8'hC0);
        #1 chk({byteAck, subaddr, 1'h0, dataPtr}, 12'hB00);
        m.send(8'hC0);
        #1 chk({byteAck, subaddr, 1'h0, dataPtr}, 12'h300);
        repeat (3) @(posedge core_clk);
        #1 chk({10'h000, dispData[3:2]}, 12'h003);
        // =====================================================
        // moved subaddress pins, then each drive mode's storage
        @(posedge core_clk) hwSubaddr <= 3'h3;
        m.send(8'h40);
        #1 chk({byteAck, subaddr, 1'h0, dataPtr}, 12'hB01);
        m.start;
        m.send(8'h80);
        cmd(8'hF8, 12'hA62);
        m.send(8'h80);
        cmd(8'h00, 12'hA62);
        m.send(8'h40);
        m.send(8'h80);
        look(6'h00);
        chk({8'h00, dispData}, 12'h006);
        chk({10'h000, dispBankBits}, 12'h002);
        m.start;
        m.send(8'h80);
        cmd(8'hF9, 12'hA6A);
        look(6'h00);
        chk({10'h000, dispBankBits}, 12'h001);
        m.send(8'h80);
        cmd(8'hC3, 12'h36A);
        look(6'h00);
        chk({10'h000, dispBankBits}, 12'h002);
        m.send(8'h80);
        cmd(8'hF5, 12'h369);
        m.send(8'h80);
        cmd(8'h01, 12'h369);
        m.send(8'h40);
        m.send(8'hA0);
        look(6'h01);
        chk({9'h000, dispData[2:0]}, 12'h005);
        m.start;
        m.send(8'h80);
        cmd(8'hC8, 12'h869);
        m.send(8'h80);
        cmd(8'h02, 12'h869);
        m.send(8'h40);
        m.send(8'h9F);
        look(6'h02);
        chk({8'h00, dispData}, 12'h009);
        chk({10'h000, dispBankBits}, 12'h001);
        m.start;
        m.send(8'h80);
        cmd(8'hC5, 12'h569);
        m.send(8'h80);
        cmd(8'h02, 12'h569);
        m.send(8'h40);
        m.send(8'h00);
        look(6'h02);
        chk({8'h00, dispData}, 12'h008);
        chk({10'h000, dispBankBits}, 12'h002);
        // =====================================================
        // reset in mid-run
        @(posedge core_clk) srst <= 1'h1;
        @(posedge core_clk) srst <= 1'h0;
        #1 chk(sts, 12'h000);
        chk({5'h00, dataPtr}, 12'h000);
        conclude;
    end
endmodule
